//--- common/scsoc_pkg.sv
// Purpose: shared constants for the scan converter status and output
//          control register bank
// Assumes: byte wide register port, 10 MHz device clock
// Notes:   register offsets, field positions, shadow reset values and window counts live here
package scsoc_pkg;

  // ==========================================================
  // byte addresses of the register bank
  localparam logic [7:0] ADDR_SW_CTRL_LO  = 8'h60;
  localparam logic [7:0] ADDR_STATUS_LO   = 8'h62;
  localparam logic [7:0] ADDR_STATUS_HI   = 8'h63;
  localparam logic [7:0] ADDR_OUT_CTRL_LO = 8'h64;
  localparam logic [7:0] ADDR_OUT_CTRL_HI = 8'h65;
  localparam logic [7:0] ADDR_EXT_CTRL_LO = 8'h66;

  // ==========================================================
  // software control low byte field
  localparam int CLR_CHANGE_COMPLETE_BIT = 3;

  // ==========================================================
  // software status low byte fields
  localparam int ST_READY_BIT      = 0;
  localparam int ST_ERROR_BIT      = 1;
  localparam int ST_CHG_START_BIT  = 2;
  localparam int ST_CHG_DONE_BIT   = 3;
  localparam int ST_CAL_ACQ_BIT    = 4;
  localparam int ST_VSYNC_ACT_BIT  = 5;
  localparam int ST_HSYNC_ACT_BIT  = 6;

  // ==========================================================
  // output control shadow fields (low byte, then high byte)
  localparam int OC_CLOCKS_PD_BIT  = 1;
  localparam int OC_ADC_PD_BIT     = 2;
  localparam int OC_COMP_PD_BIT    = 3;
  localparam int OC_YC_PD_BIT      = 4;
  localparam int OC_NOTCH_BIT      = 5;
  localparam int OC_BANDPASS_BIT   = 6;
  localparam int OC_PEDESTAL_BIT   = 7;
  localparam int OC_CLKSEL_LSB     = 0;
  localparam int OC_SCAN_BIT       = 2;
  localparam int OC_STANDARD_BIT   = 3;
  localparam int OC_FORMAT_LSB     = 4;

  // ==========================================================
  // extended control shadow low fields
  localparam int EC_ZOOM_BIT       = 0;
  localparam int EC_GAIN_BIT       = 1;
  localparam int EC_FREEZE_BIT     = 2;
  localparam int EC_INTL_DET_BIT   = 5;

  // ==========================================================
  // reset values and writable-bit masks
  localparam logic [15:0] OUT_CTRL_RESET   = 16'h0080;
  localparam logic [7:0]  EXT_CTRL_RESET   = 8'h00;
  localparam logic [7:0]  OUT_CTRL_LO_MASK = 8'hfe;
  localparam logic [7:0]  OUT_CTRL_HI_MASK = 8'h3f;
  localparam logic [7:0]  EXT_CTRL_LO_MASK = 8'h27;
  localparam logic [3:0]  MODE_FIELD_MASK  = 4'hf;

  // ==========================================================
  // mode range limits
  localparam logic [15:0] MIN_SYNC_COUNT   = 16'h0020;
  localparam logic [6:0]  MIN_ACTIVE_PCT   = 7'h14;
  localparam logic [15:0] MIN_TOTAL_SIZE   = 16'h0080;

  // ==========================================================
  // output clock source and output format codes
  localparam logic [1:0] CLKSEL_4FSC  = 2'h0;
  localparam logic [1:0] CLKSEL_NONSC = 2'h1;
  localparam logic [1:0] CLKSEL_8FSC  = 2'h2;
  localparam logic [1:0] FMT_YC_COMP  = 2'h0;
  localparam logic [1:0] FMT_RGB      = 2'h1;

  // ==========================================================
  // timing
  localparam int CLK_FREQ_HZ        = 10_000_000;
  localparam int SYNC_WINDOW_MS     = 100;
  localparam int SYNC_WINDOW_CYCLES = SYNC_WINDOW_MS * (CLK_FREQ_HZ / 1000);

endpackage

//--- core/scsoc_regbank.sv
// Purpose: status and output-mode control registers of the scan converter
// Assumes: serial control port decoder delivers one byte access per strobe
// Notes:   control outputs are registered copies, one cycle behind the bank
//
// What this block does
// - ready flag low until controller initialised
// - error flag on out-of-range mode parameters
// - mode-change-started set on change, cleared after calc
// - mode-change-complete sticky until host clear
// - vertical sync activity over last window
// - horizontal sync activity over last window
// - checksum shown in high status byte
// - power-down bits switch off their units
// - notch and bandpass filters inserted by bits
// - black pedestal inserted when bit set
// - two-bit output clock source decode
// - scan type and tv standard select
// - output format decode, top codes both yuv
// - clock scan standard change reinitialises output mode
// - clear-complete request bit self-clears after use
`timescale 1ns/1ns
module scsoc_regbank
  import scsoc_pkg::*;
#(
  parameter int SYNC_WINDOW_LEN = SYNC_WINDOW_CYCLES
)
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // byte register port from the serial control decoder
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  // internal controller events and measurements
  input  wire logic        CTRL_READY,
  input  wire logic        MODE_CHANGE_DET,
  input  wire logic        CALC_DONE,
  input  wire logic [15:0] IN_HCOUNT,
  input  wire logic [15:0] IN_VCOUNT,
  input  wire logic [6:0]  HACTIVE_PCT,
  input  wire logic [6:0]  VACTIVE_PCT,
  input  wire logic [15:0] TOTAL_PIXELS,
  input  wire logic [15:0] TOTAL_LINES,
  input  wire logic [7:0]  CHECKSUM_IN,
  // capture window calibration sample
  input  wire logic        CAL_SAMPLE,
  input  wire logic [11:0] CAL_H_START,
  input  wire logic [11:0] CAL_H_END,
  input  wire logic [11:0] CAL_V_START,
  input  wire logic [11:0] CAL_V_END,
  output logic             USE_CAL_DEFAULTS,
  // sync pins, asynchronous
  input  wire logic        HSYNC_IN,
  input  wire logic        VSYNC_IN,
  // encoder power and filter controls
  output logic             CLOCKS_PD,
  output logic             INPUT_ADC_PD,
  output logic             COMPOSITE_PD,
  output logic             LUMA_CHROMA_PD,
  output logic             LUMA_NOTCH_ON,
  output logic             CHROMA_BANDPASS_ON,
  output logic             BLACK_PEDESTAL_ON,
  // output mode controls
  output logic             CLK_SRC_4FSC,
  output logic             CLK_SRC_NONSC,
  output logic             CLK_SRC_8FSC,
  output logic             SCAN_PROGRESSIVE,
  output logic             STANDARD_PAL,
  output logic             FMT_YC_COMPOSITE,
  output logic             FMT_RGB_OUT,
  output logic             FMT_YUV_OUT,
  output logic             OUTPUT_REINIT,
  // extended controls
  output logic             ZOOM_ON,
  output logic             INPUT_GAIN_HIGH,
  output logic             FREEZE_ON,
  output logic             INTERLACED_DETECT_ON
);

  // ==========================================================
  // helpers

  // any parameter too small to calculate a mode
  function automatic logic out_of_range(
    input logic [15:0] hc,
    input logic [15:0] vc,
    input logic [6:0]  hp,
    input logic [6:0]  vp,
    input logic [15:0] tp,
    input logic [15:0] tl
  );
    out_of_range = (hc < MIN_SYNC_COUNT) || (vc < MIN_SYNC_COUNT) ||
                   (hp < MIN_ACTIVE_PCT) || (vp < MIN_ACTIVE_PCT) ||
                   (tp < MIN_TOTAL_SIZE) || (tl < MIN_TOTAL_SIZE);
  endfunction

  // write strobe for one byte address
  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = REG_WR && (REG_ADDR == a);
  endfunction

  // ==========================================================
  // state
  logic        ready_r;       // controller ready
  logic        error_r;       // mode out of range
  logic        chg_start_r;   // mode change in progress
  logic        chg_done_r;    // mode change complete, sticky
  logic        cal_acq_r;     // calibration acquired
  logic        vs_act_r;      // vsync seen in last window
  logic        hs_act_r;      // hsync seen in last window
  logic [7:0]  cksum_r;       // firmware checksum copy
  logic        clr_req_r;     // clear-complete request
  logic [7:0]  oc_lo_r;       // output control shadow low
  logic [7:0]  oc_hi_r;       // output control shadow high
  logic [7:0]  ec_lo_r;       // extended control shadow low
  logic        reinit_r;      // one-cycle reinit pulse
  logic [7:0]  status_lo;     // assembled status byte
  logic        cal_ok;        // window values acceptable
  logic        chg_done_nxt;
  logic        win_end;       // last cycle of a sync window
  logic [19:0] win_cnt_r;     // sync window counter
  logic        hs_meta_r;     // sync stage 1, read only by stage 2
  logic        hs_sync_r;
  logic        hs_prev_r;
  logic        vs_meta_r;
  logic        vs_sync_r;
  logic        vs_prev_r;
  logic        hs_seen_r;     // edge seen in current window
  logic        vs_seen_r;
  logic        hs_edge;
  logic        vs_edge;

  // ==========================================================
  // controller status flags

  // ready stays low until the controller reports done
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      ready_r <= 1'b0;
    else if (CTRL_READY)
      ready_r <= 1'b1;
  end

  // error is judged on the parameters present when calc finishes
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      error_r <= 1'b0;
    else if (CALC_DONE)
      error_r <= out_of_range(IN_HCOUNT, IN_VCOUNT, HACTIVE_PCT,
                              VACTIVE_PCT, TOTAL_PIXELS,
                              TOTAL_LINES);
  end

  // a new change wins over a finishing calculation
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      chg_start_r <= 1'b0;
    else if (MODE_CHANGE_DET)
      chg_start_r <= 1'b1;
    else if (CALC_DONE)
      chg_start_r <= 1'b0;
  end

  // completion set wins over a host clear in the same cycle
  assign chg_done_nxt = CALC_DONE | (chg_done_r & ~clr_req_r);

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      chg_done_r <= 1'b0;
    else
      chg_done_r <= chg_done_nxt;
  end

  // request lives one cycle; it clears the flag and also reads back as bit 3
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      clr_req_r <= 1'b0;
    else if (wr_hit(ADDR_SW_CTRL_LO))
      clr_req_r <= REG_WDATA[CLR_CHANGE_COMPLETE_BIT];
    else
      clr_req_r <= 1'b0;
  end

  // ==========================================================
  // input calibration

  assign cal_ok = (CAL_H_END > CAL_H_START) && (CAL_V_END > CAL_V_START);

  // mode change forces a re-acquire; an acceptable sample wins
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      cal_acq_r <= 1'b0;
    else if (CAL_SAMPLE && cal_ok)
      cal_acq_r <= 1'b1;
    else if (MODE_CHANGE_DET)
      cal_acq_r <= 1'b0;
  end

  // ==========================================================
  // sync activity monitor

  // two-stage synchronisers, edges taken after stage 2 only
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      hs_meta_r <= 1'b0;
      hs_sync_r <= 1'b0;
      hs_prev_r <= 1'b0;
      vs_meta_r <= 1'b0;
      vs_sync_r <= 1'b0;
      vs_prev_r <= 1'b0;
    end
    else
    begin
      hs_meta_r <= HSYNC_IN;
      hs_sync_r <= hs_meta_r;
      hs_prev_r <= hs_sync_r;
      vs_meta_r <= VSYNC_IN;
      vs_sync_r <= vs_meta_r;
      vs_prev_r <= vs_sync_r;
    end
  end

  assign hs_edge = hs_sync_r & ~hs_prev_r;
  assign vs_edge = vs_sync_r & ~vs_prev_r;
  assign win_end = (win_cnt_r == 20'(SYNC_WINDOW_LEN - 1));

  // free-running window counter
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      win_cnt_r <= 20'h00000;
    else if (win_end)
      win_cnt_r <= 20'h00000;
    else
      win_cnt_r <= win_cnt_r + 20'h00001;
  end

  // an edge in the closing cycle still counts for that window
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      hs_seen_r <= 1'b0;
      vs_seen_r <= 1'b0;
      hs_act_r  <= 1'b0;
      vs_act_r  <= 1'b0;
    end
    else if (win_end)
    begin
      vs_act_r  <= vs_seen_r | vs_edge;
      hs_act_r  <= hs_seen_r | hs_edge;
      hs_seen_r <= 1'b0;
      vs_seen_r <= 1'b0;
    end
    else
    begin
      hs_seen_r <= hs_seen_r | hs_edge;
      vs_seen_r <= vs_seen_r | vs_edge;
    end
  end

  // checksum copied each cycle from the controller
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      cksum_r <= 8'h00;
    else
      cksum_r <= CHECKSUM_IN;
  end

  // ==========================================================
  // host writable shadows

  // status bytes have no write path at all, so a stray write is inert
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      oc_lo_r <= OUT_CTRL_RESET[7:0];
      oc_hi_r <= OUT_CTRL_RESET[15:8];
      ec_lo_r <= EXT_CTRL_RESET;
    end
    else
    begin
      if (wr_hit(ADDR_OUT_CTRL_LO))
        oc_lo_r <= REG_WDATA & OUT_CTRL_LO_MASK;
      if (wr_hit(ADDR_OUT_CTRL_HI))
        oc_hi_r <= REG_WDATA & OUT_CTRL_HI_MASK;
      if (wr_hit(ADDR_EXT_CTRL_LO))
        ec_lo_r <= REG_WDATA & EXT_CTRL_LO_MASK;
    end
  end

  // pulse when clock, scan or standard bits actually change
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      reinit_r <= 1'b0;
    else
      reinit_r <= wr_hit(ADDR_OUT_CTRL_HI) &&
                  ((REG_WDATA[3:0] ^ oc_hi_r[3:0]) != 4'h0);
  end

  // ==========================================================
  // read side

  // status byte; bit 7 stays zero
  always_comb
  begin
    status_lo = 8'h00;
    status_lo[ST_READY_BIT]     = ready_r;
    status_lo[ST_ERROR_BIT]     = error_r;
    status_lo[ST_CHG_START_BIT] = chg_start_r;
    status_lo[ST_CHG_DONE_BIT]  = chg_done_r;
    status_lo[ST_CAL_ACQ_BIT]   = cal_acq_r;
    status_lo[ST_VSYNC_ACT_BIT] = vs_act_r;
    status_lo[ST_HSYNC_ACT_BIT] = hs_act_r;
  end

  // one byte per address; unmapped addresses read zero
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      REG_RDATA <= 8'h00;
    else if (REG_RD)
    begin
      case (REG_ADDR)
        ADDR_SW_CTRL_LO:  REG_RDATA <= {4'h0, clr_req_r, 3'h0};
        ADDR_STATUS_LO:   REG_RDATA <= status_lo;
        ADDR_STATUS_HI:   REG_RDATA <= cksum_r;
        ADDR_OUT_CTRL_LO: REG_RDATA <= oc_lo_r;
        ADDR_OUT_CTRL_HI: REG_RDATA <= oc_hi_r;
        ADDR_EXT_CTRL_LO: REG_RDATA <= ec_lo_r;
        default:          REG_RDATA <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // registered control outputs, one cycle behind the shadows
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      CLOCKS_PD            <= 1'b0;
      INPUT_ADC_PD         <= 1'b0;
      COMPOSITE_PD         <= 1'b0;
      LUMA_CHROMA_PD       <= 1'b0;
      LUMA_NOTCH_ON        <= 1'b0;
      CHROMA_BANDPASS_ON   <= 1'b0;
      BLACK_PEDESTAL_ON    <= 1'b0;
      CLK_SRC_4FSC         <= 1'b0;
      CLK_SRC_NONSC        <= 1'b0;
      CLK_SRC_8FSC         <= 1'b0;
      SCAN_PROGRESSIVE     <= 1'b0;
      STANDARD_PAL         <= 1'b0;
      FMT_YC_COMPOSITE     <= 1'b0;
      FMT_RGB_OUT          <= 1'b0;
      FMT_YUV_OUT          <= 1'b0;
      ZOOM_ON              <= 1'b0;
      INPUT_GAIN_HIGH      <= 1'b0;
      FREEZE_ON            <= 1'b0;
      INTERLACED_DETECT_ON <= 1'b0;
      USE_CAL_DEFAULTS     <= 1'b1;
      OUTPUT_REINIT        <= 1'b0;
    end
    else
    begin
      CLOCKS_PD          <= oc_lo_r[OC_CLOCKS_PD_BIT];
      INPUT_ADC_PD       <= oc_lo_r[OC_ADC_PD_BIT];
      COMPOSITE_PD       <= oc_lo_r[OC_COMP_PD_BIT];
      LUMA_CHROMA_PD     <= oc_lo_r[OC_YC_PD_BIT];
      LUMA_NOTCH_ON      <= oc_lo_r[OC_NOTCH_BIT];
      CHROMA_BANDPASS_ON <= oc_lo_r[OC_BANDPASS_BIT];
      BLACK_PEDESTAL_ON  <= oc_lo_r[OC_PEDESTAL_BIT];
      // code 11 selects no source
      CLK_SRC_4FSC  <= oc_hi_r[OC_CLKSEL_LSB+:2] == CLKSEL_4FSC;
      CLK_SRC_NONSC <= oc_hi_r[OC_CLKSEL_LSB+:2] == CLKSEL_NONSC;
      CLK_SRC_8FSC  <= oc_hi_r[OC_CLKSEL_LSB+:2] == CLKSEL_8FSC;
      SCAN_PROGRESSIVE <= oc_hi_r[OC_SCAN_BIT];
      STANDARD_PAL     <= oc_hi_r[OC_STANDARD_BIT];
      FMT_YC_COMPOSITE <= oc_hi_r[OC_FORMAT_LSB+:2] == FMT_YC_COMP;
      FMT_RGB_OUT      <= oc_hi_r[OC_FORMAT_LSB+:2] == FMT_RGB;
      FMT_YUV_OUT      <= oc_hi_r[OC_FORMAT_LSB+1];
      ZOOM_ON              <= ec_lo_r[EC_ZOOM_BIT];
      INPUT_GAIN_HIGH      <= ec_lo_r[EC_GAIN_BIT];
      FREEZE_ON            <= ec_lo_r[EC_FREEZE_BIT];
      INTERLACED_DETECT_ON <= ec_lo_r[EC_INTL_DET_BIT];
      USE_CAL_DEFAULTS     <= ~cal_acq_r;
      OUTPUT_REINIT        <= reinit_r;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_ready_sticky: assert property (ready_r |=> ready_r)
    else $error("ready flag dropped");
  a_error_calc: assert property (CALC_DONE |=> error_r ==
    $past(out_of_range(IN_HCOUNT, IN_VCOUNT, HACTIVE_PCT, VACTIVE_PCT,
                       TOTAL_PIXELS, TOTAL_LINES)))
    else $error("error flag wrong after calc");
  a_start_clear: assert property (
    CALC_DONE && !MODE_CHANGE_DET |=> !chg_start_r)
    else $error("mode change started not cleared");
  a_done_clear_path: assert property (
    wr_hit(ADDR_SW_CTRL_LO) && REG_WDATA[CLR_CHANGE_COMPLETE_BIT] &&
    !CALC_DONE ##1 !CALC_DONE |=> !chg_done_r)
    else $error("complete flag not cleared by request");
  a_done_hold: assert property (
    chg_done_r && !clr_req_r |=> chg_done_r)
    else $error("complete flag lost");
  a_clr_self: assert property (
    clr_req_r && !wr_hit(ADDR_SW_CTRL_LO) |=> !clr_req_r)
    else $error("clear request did not self clear");
  a_cal_cause: assert property (
    $rose(cal_acq_r) |-> $past(CAL_SAMPLE && cal_ok))
    else $error("calibration acquired without sample");
  a_cal_default: assert property (
    !cal_acq_r ##1 !cal_acq_r |-> USE_CAL_DEFAULTS)
    else $error("defaults not used before calibration");
  a_vsync_window: assert property (
    win_end && !vs_seen_r && !vs_edge |=> !vs_act_r)
    else $error("vsync activity without pulses");
  a_hsync_window: assert property (
    win_end && hs_edge |=> hs_act_r)
    else $error("hsync activity missed");
  a_cksum_read: assert property (
    REG_RD && REG_ADDR == ADDR_STATUS_HI |=> REG_RDATA == $past(cksum_r))
    else $error("checksum read mismatch");
  a_pd_follow: assert property (1'b1 |=>
    CLOCKS_PD == $past(oc_lo_r[OC_CLOCKS_PD_BIT]) &&
    LUMA_CHROMA_PD == $past(oc_lo_r[OC_YC_PD_BIT]))
    else $error("power down output mismatch");
  a_reinit_pulse: assert property (
    wr_hit(ADDR_OUT_CTRL_HI) &&
    REG_WDATA[OC_SCAN_BIT] != oc_hi_r[OC_SCAN_BIT]
    |=> ##1 OUTPUT_REINIT)
    else $error("no reinit on scan change");
  a_reserved_zero: assert property (
    !oc_lo_r[0] && oc_hi_r[7:6] == 2'h0 && ec_lo_r[7:6] == 2'h0)
    else $error("reserved bit set");

  c_mode_change: cover property (MODE_CHANGE_DET ##[1:50] CALC_DONE);
  c_done_cleared: cover property (chg_done_r ##1 clr_req_r ##1 !chg_done_r);
  c_vsync_seen: cover property (win_end && vs_seen_r);
  c_reinit: cover property (OUTPUT_REINIT);

endmodule

//--- tb/scsoc_host_model.sv
// Purpose: host side of the byte register port, one access at a time
// Assumes: strobes are taken at a rising edge, reads answer a cycle later
// Notes:   released address and data lines carry inverted junk, not stale
`timescale 1ns/1ns
module scsoc_host_model
(
  // clock
  input  wire logic       clk,
  // byte port toward the bank
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // ==========================================================
  // expected read bytes, oldest first, taken by the bench monitor
  logic [7:0] exp_q [$];
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // ==========================================================
  // one write, held to its edge; status bytes are never aimed at
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
    @(posedge clk);
    #1;
  endtask
  // one read; the expected byte is noted before the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    @(posedge clk);
    #1;
  endtask
endmodule

//--- tb/scsoc_regbank_tb.sv
// Purpose: self-checking bench for the status and output control bank
// Assumes: sync window shortened to 64 cycles
// Notes:   reads are scored by a monitor against the host's queue
`timescale 1ns/1ns
`define CHK(a, e) \
  begin \
    num_checks++; \
    if ((a) !== (e)) \
    begin \
      n_mismatch++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end
module scsoc_regbank_tb
  import scsoc_pkg::*;
;
  // ==========================================================
  // bank ports
  logic        CLK, RSTN, REG_WR, REG_RD, CTRL_READY, MODE_CHANGE_DET;
  logic        CALC_DONE, CAL_SAMPLE, HSYNC_IN, VSYNC_IN, USE_CAL_DEFAULTS;
  logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, CHECKSUM_IN;
  logic [15:0] IN_HCOUNT, IN_VCOUNT, TOTAL_PIXELS, TOTAL_LINES;
  logic [6:0]  HACTIVE_PCT, VACTIVE_PCT;
  logic [11:0] CAL_H_START, CAL_H_END, CAL_V_START, CAL_V_END;
  logic        CLOCKS_PD, INPUT_ADC_PD, COMPOSITE_PD, LUMA_CHROMA_PD;
  logic        LUMA_NOTCH_ON, CHROMA_BANDPASS_ON, BLACK_PEDESTAL_ON;
  logic        CLK_SRC_4FSC, CLK_SRC_NONSC, CLK_SRC_8FSC, SCAN_PROGRESSIVE;
  logic        STANDARD_PAL, FMT_YC_COMPOSITE, FMT_RGB_OUT, FMT_YUV_OUT;
  logic        OUTPUT_REINIT, ZOOM_ON, INPUT_GAIN_HIGH, FREEZE_ON;
  logic        INTERLACED_DETECT_ON;
  // bench state
  int          n_mismatch = 0;   // failed comparisons
  int          num_checks = 0;   // comparisons made
  logic [6:0]  st;               // expected status low byte
  logic [7:0]  ck, r4, v5, r6, p5;
  logic        rd_d1, rd_d2;     // read strobe delayed to data time
  // clock, scan and standard sets a host should use
  logic [3:0]  rec [8] = '{4'h0, 4'h8, 4'h6, 4'he, 4'h9, 4'h5, 4'h2, 4'ha};
  scsoc_regbank #(.SYNC_WINDOW_LEN(64)) scsoc_regbank_i (.*);
  scsoc_host_model scsoc_host_model_i (.clk(CLK), .reg_addr(REG_ADDR),
    .reg_wdata(REG_WDATA), .reg_wr(REG_WR), .reg_rd(REG_RD));
  initial
  begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // ==========================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    scsoc_host_model_i.wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    scsoc_host_model_i.rd(a, e);
  endtask
  task automatic rs();
    rd(ADDR_STATUS_LO, {1'b0, st});
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // monitor: read data settles one cycle after the strobe edge
  always @(posedge CLK)
  begin
    rd_d1 <= REG_RD;
    rd_d2 <= rd_d1;
  end
  always @(negedge CLK)
    if (rd_d2 === 1'b1)
      `CHK(REG_RDATA, scsoc_host_model_i.exp_q.pop_front())
  // watchdog, far beyond the fewer than a thousand cycles the tests need
  initial
  begin
    #(100 * 20000);
    n_mismatch++;
    final_report();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    {RSTN, CTRL_READY, MODE_CHANGE_DET, CALC_DONE, CAL_SAMPLE} = 5'h00;
    {HSYNC_IN, VSYNC_IN} = 2'h0;
    {IN_HCOUNT, IN_VCOUNT, TOTAL_PIXELS, TOTAL_LINES} = 64'h0;
    {HACTIVE_PCT, VACTIVE_PCT} = 14'h0;
    {CAL_H_START, CAL_H_END, CAL_V_START, CAL_V_END} = 48'h0;
    {st, p5} = 15'h0;
    void'($urandom(74));
    ck = 8'($urandom);
    CHECKSUM_IN = ck;
    tick(2);
    RSTN = 1'b1;
    tick(1);
    `CHK({BLACK_PEDESTAL_ON, USE_CAL_DEFAULTS, CLK_SRC_4FSC}, 3'h7)
    rs();
    rd(ADDR_STATUS_HI, ck);
    rd(ADDR_OUT_CTRL_LO, OUT_CTRL_RESET[7:0]);
    rd(ADDR_OUT_CTRL_HI, OUT_CTRL_RESET[15:8]);
    rd(8'h67, 8'h00);
    $display("test reset finished");
    pulse(CTRL_READY);
    st[0] = 1'b1;
    rs();
    {CAL_H_START, CAL_V_START} = {12'($urandom % 2048), 12'($urandom % 2048)};
    {CAL_H_END, CAL_V_END} = {CAL_H_START, CAL_V_START};
    pulse(CAL_SAMPLE);
    rs();
    {CAL_H_END, CAL_V_END} = {CAL_H_START + 12'h1, CAL_V_START + 12'h1};
    pulse(CAL_SAMPLE);
    st[4] = 1'b1;
    rs();
    `CHK(USE_CAL_DEFAULTS, 1'b0)
    pulse(MODE_CHANGE_DET);
    st[4:2] = 3'b001;
    rs();
    for (int i = 0; i < 7; i++)
    begin
      {IN_HCOUNT, IN_VCOUNT} = {MIN_SYNC_COUNT, MIN_SYNC_COUNT};
      {TOTAL_PIXELS, TOTAL_LINES} = {MIN_TOTAL_SIZE, MIN_TOTAL_SIZE};
      {HACTIVE_PCT, VACTIVE_PCT} = {MIN_ACTIVE_PCT, MIN_ACTIVE_PCT};
      case (i)
        0: IN_HCOUNT = 16'h001f;
        1: IN_VCOUNT = 16'h001f;
        2: HACTIVE_PCT = 7'h13;
        3: VACTIVE_PCT = 7'h13;
        4: TOTAL_PIXELS = 16'h007f;
        5: TOTAL_LINES = 16'h007f;
        default: ;
      endcase
      pulse(CALC_DONE);
      st[3:1] = {2'b10, i != 6};
      rs();
    end
    wr(ADDR_SW_CTRL_LO, 8'h08);
    tick(1);
    st[3] = 1'b0;
    rs();
    rd(ADDR_SW_CTRL_LO, 8'h00);
    $display("test status events finished");
    for (int k = 0; k < 16; k++)
    begin
      v5 = {2'($urandom), k[1:0], (k < 8) ? rec[k[2:0]] : k[3:0]};
      wr(ADDR_OUT_CTRL_HI, v5);
      // the reinit pulse stands one cycle only, so look at it right away
      `CHK(OUTPUT_REINIT, v5[3:0] != p5[3:0])
      p5 = v5;
      r4 = 8'($urandom);
      r6 = 8'($urandom);
      wr(ADDR_OUT_CTRL_LO, r4);
      wr(ADDR_EXT_CTRL_LO, r6);
      tick(1);
      `CHK({BLACK_PEDESTAL_ON, CHROMA_BANDPASS_ON, LUMA_NOTCH_ON,
        LUMA_CHROMA_PD, COMPOSITE_PD, INPUT_ADC_PD, CLOCKS_PD},
        r4[7:1])
      `CHK({FMT_YUV_OUT, FMT_RGB_OUT, FMT_YC_COMPOSITE, STANDARD_PAL,
        SCAN_PROGRESSIVE, CLK_SRC_8FSC, CLK_SRC_NONSC, CLK_SRC_4FSC},
        {v5[5], v5[5:4] == 2'h1, v5[5:4] == 2'h0, v5[3:2], v5[1:0] == 2'h2,
        v5[1:0] == 2'h1, v5[1:0] == 2'h0})
      `CHK({INTERLACED_DETECT_ON, FREEZE_ON, INPUT_GAIN_HIGH, ZOOM_ON},
        {r6[5], r6[2:0]})
      rd(ADDR_OUT_CTRL_LO, r4 & OUT_CTRL_LO_MASK);
      rd(ADDR_OUT_CTRL_HI, v5 & OUT_CTRL_HI_MASK);
      rd(ADDR_EXT_CTRL_LO, r6 & EXT_CTRL_LO_MASK);
    end
    $display("test output controls finished");
    for (int p = 0; p < 2; p++)
    begin
      repeat (80)
      begin
        if (p == 0)
          HSYNC_IN = ~HSYNC_IN;
        else
          VSYNC_IN = ~VSYNC_IN;
        tick(2);
      end
      st[6 - p] = 1'b1;
      rs();
      tick(140);
      st[6 - p] = 1'b0;
      rs();
    end
    $display("test sync activity finished");
    tick(4);
    final_report();
  end
endmodule
